// ### hw/partner_emu.sv
`timescale 1ns/10ps
`default_nettype none
`include "partner_emu_defines.svh"
module partner_emu (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic duplex_strap,
	input wire logic speed_strap,
	input wire logic flow_control_pause_strap,
	input wire logic [15:0] local_adv,
	input wire logic an_restart,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [11:0] mem_addr,
	input wire logic mii_rd,
	input wire logic mii_wr,
	input wire logic [4:0] mii_index,
	output logic [31:0] mem_rdata,
	output logic [15:0] mii_rdata,
	output logic [15:0] partner_ability,
	output logic an_complete
);
	partner_emu_pkg::an_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic page_rx_q, page_rx_d;
	logic [1:0] pause_q, pause_d;
	logic [3:0] abil_q, abil_d;
	logic an_ok_q, an_ok_d;
	logic [31:0] mem_rdata_d;
	logic [15:0] mii_rdata_d;
	logic [15:0] exp_val;
	logic exp_rd;
	logic [3:0] strap_abil;
	logic [1:0] pause_calc;
	logic mem_sel;
	logic mii_sel;

	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// Strap decode and pause resolution.
	always_comb begin
		unique case ({duplex_strap, speed_strap})
			2'b10: strap_abil = `ABIL_10_FULL;
			2'b11: strap_abil = `ABIL_100_FULL;
			2'b00: strap_abil = `ABIL_10_HALF;
			2'b01: strap_abil = `ABIL_100_HALF;
		endcase
		unique case ({local_adv[`PAUSE_ASYM_BIT], local_adv[`PAUSE_SYM_BIT]})
			2'b00: pause_calc = 2'b00;
			2'b01: pause_calc = 2'b01;
			2'b10: pause_calc = 2'b11;
			2'b11: pause_calc = flow_control_pause_strap ? 2'b11 : 2'b10;
		endcase
	end

	assign mem_sel = mem_rd && (mem_addr == `EXP_OFFSET);
	assign mii_sel = mii_rd && (mii_index == `EXP_MII_INDEX);
	assign exp_rd = mem_sel || mii_sel;

	always_comb begin
		exp_val = 16'h0000;
		exp_val[`EXP_BIT_PD_FAULT] = 1'b0;
		exp_val[`EXP_BIT_LP_NP] = 1'b0;
		exp_val[`EXP_BIT_LOC_NP] = 1'b0;
		exp_val[`EXP_BIT_PAGE_RX] = page_rx_q;
		exp_val[`EXP_BIT_LP_AN] = an_ok_q;
	end

	// Negotiation runs a short delay after reset or restart.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		pause_d = pause_q;
		abil_d = abil_q;
		an_ok_d = an_ok_q;
		page_rx_d = page_rx_q;
		if (exp_rd) begin
			page_rx_d = 1'b0;
		end
		unique case (st_q)
			partner_emu_pkg::AN_IDLE: begin
				cnt_d = 4'h0;
				st_d = partner_emu_pkg::AN_WAIT;
			end
			partner_emu_pkg::AN_WAIT: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `AN_DELAY_CYCLES) begin
					st_d = partner_emu_pkg::AN_DONE;
					pause_d = pause_calc;
					an_ok_d = |(local_adv[`ABIL_MSB:`ABIL_LSB] & strap_abil);
					// Failure is folded in here so the output stays a flop.
					abil_d = an_ok_d ? strap_abil : 4'h0;
					// set after negotiation; set beats clear
					page_rx_d = 1'b1;
				end
			end
			partner_emu_pkg::AN_DONE: begin
				if (an_restart) begin
					st_d = partner_emu_pkg::AN_IDLE;
				end
			end
			default: st_d = partner_emu_pkg::AN_IDLE;
		endcase
		mem_rdata_d = 32'h0000_0000;
		mii_rdata_d = 16'h0000;
		if (mem_sel) begin
			mem_rdata_d = {16'h0000, exp_val};
		end
		if (mii_sel) begin
			mii_rdata_d = exp_val;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= partner_emu_pkg::AN_IDLE;
			cnt_q <= 4'h0;
			page_rx_q <= 1'b0;
			pause_q <= 2'b00;
			abil_q <= 4'h0;
			an_ok_q <= 1'b1;
			mem_rdata <= 32'h0000_0000;
			mii_rdata <= 16'h0000;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			page_rx_q <= page_rx_d;
			pause_q <= pause_d;
			abil_q <= abil_d;
			an_ok_q <= an_ok_d;
			mem_rdata <= mem_rdata_d;
			mii_rdata <= mii_rdata_d;
		end
	end

	always_comb begin
		partner_ability = `AN_SELECTOR;
		partner_ability[`ABIL_MSB:`ABIL_LSB] = abil_q;
		partner_ability[`PAUSE_SYM_BIT] = pause_q[0];
		partner_ability[`PAUSE_ASYM_BIT] = pause_q[1];
	end
	assign an_complete = (st_q == partner_emu_pkg::AN_DONE);

	// Writes are not used; reading them keeps intent visible.
	logic unused_wr;
	assign unused_wr = mem_wr ^ mii_wr;

	// Last counting cycle of the emulated negotiation.
	sequence an_finishing;
		st_q == partner_emu_pkg::AN_WAIT && cnt_q == `AN_DELAY_CYCLES;
	endsequence : an_finishing

	chk_read_clears_page: assert property (
		exp_rd && st_q == partner_emu_pkg::AN_DONE && !an_restart
		|=> !page_rx_q)
		else $error("page flag not cleared by read");
	chk_page_set_done: assert property (
		$rose(an_complete) |-> page_rx_q)
		else $error("page flag not set at completion");
	chk_page_set_source: assert property (
		$rose(page_rx_q) |-> $past(st_q) == partner_emu_pkg::AN_WAIT)
		else $error("page flag set outside negotiation");
	chk_fixed_zero_bits: assert property (
		mii_rdata[`EXP_BIT_PD_FAULT:`EXP_BIT_LOC_NP] == 3'h0 &&
		mem_rdata[`EXP_BIT_PD_FAULT:`EXP_BIT_LOC_NP] == 3'h0 &&
		mem_rdata[`EXP_RSV_MSB:`EXP_RSV_LSB] == 16'h0000)
		else $error("fixed bits not zero");
	chk_pause_hold: assert property (
		an_complete && $past(an_complete) |-> $stable(pause_q))
		else $error("pause changed without renegotiation");
	chk_mii_read_data: assert property (
		mii_sel |=> mii_rdata[`EXP_BIT_LP_AN] == $past(an_ok_q))
		else $error("mii read wrong");
	chk_mem_read_data: assert property (
		mem_sel |=> mem_rdata[`EXP_BIT_PAGE_RX] == $past(page_rx_q))
		else $error("memory read wrong");
	chk_idle_read_zero: assert property (
		!mem_sel && !mii_sel |=> mem_rdata == 32'h0000_0000 &&
		mii_rdata == 16'h0000)
		else $error("read data without a read");
	chk_an_able_fail: assert property (
		an_finishing |=> an_ok_q ==
		|($past(local_adv[`ABIL_MSB:`ABIL_LSB]) & $past(strap_abil)))
		else $error("AN able does not match overlap");
	chk_ability_strap: assert property (
		$rose(an_complete) && an_ok_q |->
		partner_ability[`ABIL_MSB:`ABIL_LSB] == $past(strap_abil) &&
		$onehot(abil_q))
		else $error("ability code bad");
	chk_fail_no_ability: assert property (
		!an_ok_q |-> partner_ability[`ABIL_MSB:`ABIL_LSB] == 4'h0)
		else $error("ability shown after failed negotiation");
	chk_pause_strap: assert property (
		an_finishing ##0 (local_adv[`PAUSE_ASYM_BIT:`PAUSE_SYM_BIT] == 2'h3 &&
		!flow_control_pause_strap)
		|=> partner_ability[`PAUSE_ASYM_BIT:`PAUSE_SYM_BIT] == 2'h2)
		else $error("pause resolution wrong");
endmodule : partner_emu
`default_nettype wire

// ### common/partner_emu_defines.svh
`ifndef PARTNER_EMU_DEFINES_SVH
`define PARTNER_EMU_DEFINES_SVH
`define EXP_OFFSET 12'h1d8
`define EXP_MII_INDEX 5'h06
`define EXP_BIT_PD_FAULT 4
`define EXP_BIT_LP_NP 3
`define EXP_BIT_LOC_NP 2
`define EXP_BIT_PAGE_RX 1
`define EXP_BIT_LP_AN 0
`define ABIL_10_FULL 4'h2
`define ABIL_100_FULL 4'h8
`define ABIL_10_HALF 4'h1
`define ABIL_100_HALF 4'h4
`define ABIL_LSB 5
`define ABIL_MSB 8
`define PAUSE_SYM_BIT 10
`define PAUSE_ASYM_BIT 11
`define AN_DELAY_CYCLES 4'h8
`define AN_SELECTOR 16'h0001
`define EXP_RSV_MSB 31
`define EXP_RSV_LSB 16
`endif

// ### common/partner_emu_pkg.sv
`default_nettype none
package partner_emu_pkg;
	typedef enum logic [1:0] {
		AN_IDLE = 2'b00,
		AN_WAIT = 2'b01,
		AN_DONE = 2'b11
	} an_state_t;
endpackage : partner_emu_pkg
`default_nettype wire

// ### tb/mii_station.sv
`timescale 1ns/10ps
`default_nettype none
module mii_station (
	input wire logic clk_sys,
	input wire logic go,
	output logic mii_rd,
	output logic [4:0] mii_index
);
	// Index 6; idle index points elsewhere so stale reads show up.
	always_ff @(posedge clk_sys) begin
		mii_rd <= go;
		mii_index <= go ? 5'h06 : 5'h1f;
	end
endmodule : mii_station
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_sys = 1'b0, rst_b = 1'b0, dup = 1'b1, spd = 1'b1;
	logic fc = 1'b1, rs = 1'b0, go = 1'b0, mrd = 1'b0, mwr = 1'b0;
	logic xwr = 1'b0, xrd, anc;
	logic [11:0] addr = 12'h1d8;
	logic [15:0] adv = 16'h0de0, xd, pab;
	logic [4:0] idx;
	logic [31:0] md;
	logic [3:0] tab [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
	int n_errors = 0, total_checks = 0;
	always #10 clk_sys = ~clk_sys;
	partner_emu partner_emu_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.duplex_strap(dup), .speed_strap(spd),
		.flow_control_pause_strap(fc), .local_adv(adv), .an_restart(rs),
		.mem_rd(mrd), .mem_wr(mwr), .mem_addr(addr), .mii_rd(xrd),
		.mii_wr(xwr), .mii_index(idx), .mem_rdata(md), .mii_rdata(xd),
		.partner_ability(pab), .an_complete(anc));
	mii_station mii_station_inst (.clk_sys(clk_sys), .go(go),
		.mii_rd(xrd), .mii_index(idx));
	task automatic chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task final_report;
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic wait_an;
		for (int i = 0; i < 40 && anc !== 1'b1; i++)
			@(posedge clk_sys);
		if (anc !== 1'b1) begin
			chk("an_timeout", {31'h0, anc}, 32'h1);
			final_report();
		end
	endtask : wait_an
	task automatic renego(input logic d, s, f, input logic [15:0] a);
		@(posedge clk_sys);
		{dup, spd, fc, adv, rs} <= {d, s, f, a, 1'b1};
		@(posedge clk_sys);
		rs <= 1'b0;
		repeat (2) @(posedge clk_sys);
		wait_an();
	endtask : renego
	task automatic mii_rd(input logic [15:0] e, input string nm);
		@(posedge clk_sys);
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		#1 chk(nm, {16'h0000, xd}, {16'h0000, e});
	endtask : mii_rd
	task automatic mem_rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		{mrd, addr} <= {1'b1, a};
		@(posedge clk_sys);
		mrd <= 1'b0;
		#1 chk("mem", md, e);
	endtask : mem_rd
	task automatic t_reset;
		mii_rd(16'h0001, "pre");
		wait_an();
		mii_rd(16'h0003, "first");
		mii_rd(16'h0001, "cleared");
		@(posedge clk_sys);
		{mwr, xwr} <= 2'b11;
		@(posedge clk_sys);
		{mwr, xwr} <= 2'b00;
		mem_rd(12'h1d8, 32'h00000001);
		mem_rd(12'h1dc, 32'h00000000);
	endtask : t_reset
	task automatic t_ability;
		for (int i = 0; i < 4; i++) begin
			renego(i[1], i[0], 1'b1, 16'h01e0);
			chk("abil", {16'h0, pab}, {16'h0, 7'h0, tab[i], 5'h01});
			mem_rd(12'h1d8, 32'h00000003);
		end
	endtask : t_ability
	task automatic t_pause;
		logic s, a, ps;
		for (int j = 0; j < 8; j++) begin
			{s, a} = {j[0], j[1]};
			ps = (s | a) & ~(s & a & ~j[2]);
			renego(1'b1, 1'b1, j[2], {4'h0, a, s, 10'h1e0});
			chk("pause", {30'h0, pab[11:10]}, {30'h0, a, ps});
		end
		@(posedge clk_sys);
		adv <= 16'h01e0;
		repeat (2) @(posedge clk_sys);
		chk("held", {30'h0, pab[11:10]}, 32'h00000003);
	endtask : t_pause
	task automatic t_fail;
		renego(1'b1, 1'b1, 1'b1, 16'h00e0);
		chk("fail", {28'h0, pab[8:5]}, 32'h00000000);
		mii_rd(16'h0002, "noable");
	endtask : t_fail
	task automatic t_rerst;
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("rst_anc", {31'h0, anc}, 32'h0);
		chk("rst_pab", {16'h0, pab}, 32'h1);
		rst_b <= 1'b1;
		mii_rd(16'h0001, "rerst");
		wait_an();
		mii_rd(16'h0002, "refail");
	endtask : t_rerst
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_ability();
		t_pause();
		t_fail();
		t_rerst();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
